// ==== common/ssof_flag_if.sv ====
// flag vector passed from flag logic to the terminal mapper
// assumes one clock domain
`timescale 1ns/100ps
interface ssof_flag_if #(parameter int NF = 9);
    logic [NF-1:0] flag;
    modport src (output flag);
    modport dst (input flag);
endinterface

// ==== common/ssof_pkg.sv ====
// types for the servo status output flag block
// assumes the constants header is on the include path
package ssof_pkg;
    typedef enum logic [1:0] {
        SSOF_MODE_POS = 2'h0,
        SSOF_MODE_SPD = 2'h1,
        SSOF_MODE_TRQ = 2'h2
    } ssof_mode_e;
    typedef enum logic [1:0] {
        SSOF_SEQ_IDLE = 2'b00,
        SSOF_SEQ_RUN = 2'b01,
        SSOF_SEQ_WAIT = 2'b11
    } ssof_seq_e;
    typedef logic [7:0] ssof_code_t;
endpackage

// ==== common/ssof_regs.svh ====
// constants for the servo status output flag block
// assumes inclusion by bare name from design and test files
`ifndef SSOF_REGS_SVH
`define SSOF_REGS_SVH
`define SSOF_CODE_CYCLE_END_MARK 8'h15
`define SSOF_CODE_HOME 8'h16
`define SSOF_CODE_ZDEV 8'h17
`define SSOF_CODE_ZSPD 8'h18
`define SSOF_CODE_SPDM 8'h19
`define SSOF_CODE_TLIM 8'h1a
`define SSOF_CODE_OLW 8'h1b
`define SSOF_CODE_RDY 8'h1c
`define SSOF_CODE_EDIT 8'h1d
`define SSOF_CODE_FSTOP 8'h0a
`define SSOF_CODE_FREE 8'h36
`define SSOF_CODE_ALM 8'h10
`define SSOF_LAST_ENTRY 7'h63
`define SSOF_SEL_ON 1'b1
`define SSOF_PROTECT_OFF 1'b0
`define SSOF_FIRST_CODE 8'h15
`define SSOF_NUM_FLAGS 9
`endif

// ==== design/ssof_status.sv ====
// servo status output flags toward the host controller
// assumes all inputs synchronous to MCLK_IN, one control cycle per clock
//
// Overview of operation
// R1 - host starts at entry, then steps with zero
// R2 - cycle end rises with in-position
// R3 - sequencing needs both selects equal 1
// R4 - suppress cycle end when sequencing blocked
// R5 - cancel and pause keep cycle end state
// R6 - entry 99 acts as cycle end
// R7 - next start skips continuation entries
// R8 - home flag held within detect range
// R9 - range 0 or max keeps home flag
// R10 - zero deviation within width
// R11 - zero speed within range
// R12 - speed match within range of command
// R13 - speed match off under torque control
// R14 - manual jog idle or unreachable blocks match
// R15 - command speed clamped to maximum
// R16 - torque limit flag at limit
// R17 - overload warning self clears
// R18 - ready needs stop on, free off, alarm off
// R19 - edit response needs no protect and permission
// R20 - flag reaches terminal by its code
// R21 - cycle end and edit only internal variant
// R22 - unassigned flags stay off
// R23 - flags registered once per cycle
`timescale 1ns/100ps
`include "ssof_regs.svh"
module ssof_status #(
    parameter int NT = 5,
    parameter int PW = 24,
    parameter int SW = 16,
    parameter bit INTERNAL_DATA = 1'b1
) (
    // clock and reset
    input wire logic MCLK_IN,
    input wire logic RSTN_IN,
    // settings
    input wire logic SEQUENTIAL_START_SELECT_IN,
    input wire logic INTERNAL_DATA_SELECT_IN,
    input wire logic EDIT_PROTECT_SETTING_IN,
    input wire logic [PW-1:0] ZERO_DEVIATION_WIDTH_IN,
    input wire logic [SW-1:0] ZERO_SPEED_RANGE_IN,
    input wire logic [SW-1:0] SPEED_MATCH_RANGE_IN,
    input wire logic [SW-1:0] MAX_ROTATION_SPEED_IN,
    input wire logic [7*SW-1:0] MANUAL_FEED_SPEEDS_IN,
    input wire logic [PW-1:0] HOME_POSITION_VALUE_IN,
    input wire logic [PW-1:0] HOME_DETECT_RANGE_IN,
    input wire logic [7:0] OVERLOAD_WARN_LEVEL_IN,
    input wire logic [NT*8-1:0] TERM_FUNC_CODE_IN,
    // positioning sequence
    input wire logic START_POS_IN,
    input wire logic [6:0] ENTRY_NUM_IN,
    input wire logic CYCLE_END_MARK_IN,
    input wire logic CONTINUATION_MARK_IN,
    input wire logic IN_POSITION_IN,
    input wire logic SERVO_ON_IN,
    input wire logic PULSE_RATIO_IN,
    input wire logic HOMING_ACTIVE_IN,
    input wire logic HOMING_DONE_IN,
    input wire logic OVER_TRAVEL_INPUT_IN,
    input wire logic SOFT_OT_IN,
    // motion measurements
    input wire ssof_pkg::ssof_mode_e CTRL_MODE_IN,
    input wire logic INTERRUPT_POS_IN,
    input wire logic MANUAL_OP_IN,
    input wire logic FORWARD_JOG_COMMAND_IN,
    input wire logic REVERSE_JOG_COMMAND_IN,
    input wire logic [2:0] FEED_SPEED_SEL_IN,
    input wire logic HOST_SPEED_SEL_IN,
    input wire logic [SW-1:0] HOST_SPEED_IN,
    input wire logic DECEL_SLOW_IN,
    input wire logic signed [PW-1:0] CMD_POS_IN,
    input wire logic signed [PW-1:0] FB_POS_IN,
    input wire logic signed [SW-1:0] SPEED_IN,
    input wire logic [SW-1:0] TORQUE_IN,
    input wire logic [SW-1:0] TORQUE_LIMIT_IN,
    input wire logic [7:0] LOAD_FACTOR_IN,
    // ready and edit
    input wire logic FORCED_STOP_INPUT_IN,
    input wire logic FREE_RUN_INPUT_IN,
    input wire logic ALARM_IN,
    input wire logic CPU_OK_IN,
    input wire logic MAIN_POWER_IN,
    input wire logic EDIT_PERMIT_ASSIGNED_IN,
    input wire logic EDIT_PERMIT_IN,
    // outputs
    output logic [NT-1:0] TERM_OUT,
    output logic [SW-1:0] SPEED_CMD_OUT,
    output logic EDIT_ALLOWED_OUT,
    output logic [6:0] NEXT_ENTRY_OUT
);
    import ssof_pkg::*;
    initial begin
        if (NT < 1 || PW < 8 || SW < 4) begin
            $error("ssof_status: bad parameters");
        end
    end
    ssof_flag_if #(.NF(`SSOF_NUM_FLAGS)) fl ();
    ssof_seq_e state;
    ssof_seq_e next_state;
    logic cycle_end_mark;
    logic home_done;
    logic [6:0] next_entry;
    logic [`SSOF_NUM_FLAGS-1:0] flag;

    // R3 sequencing enable
    wire seq_en = INTERNAL_DATA &&
        SEQUENTIAL_START_SELECT_IN == `SSOF_SEL_ON &&
        INTERNAL_DATA_SELECT_IN == `SSOF_SEL_ON;
    // R4 blocking conditions
    wire seq_block = !SERVO_ON_IN || PULSE_RATIO_IN ||
        HOMING_ACTIVE_IN || OVER_TRAVEL_INPUT_IN || SOFT_OT_IN;
    // R1 zero entry means step onward
    wire step = START_POS_IN && ENTRY_NUM_IN == 7'h00;
    wire start_any = START_POS_IN && seq_en && !seq_block;
    // R7 a step off a continued entry goes one further
    wire [6:0] step_entry = CONTINUATION_MARK_IN ?
        next_entry + 7'h01 : next_entry;
    wire [6:0] start_entry = step ? step_entry : ENTRY_NUM_IN;
    // R6 last entry closes the cycle
    wire last_entry = CYCLE_END_MARK_IN ||
        next_entry == `SSOF_LAST_ENTRY;
    // R2 rise with in-position
    wire cycle_end_mark_hit = state == SSOF_SEQ_WAIT && IN_POSITION_IN &&
        last_entry;

    always_comb begin
        next_state = state;
        case (state)
            SSOF_SEQ_IDLE: begin
                if (start_any) begin
                    next_state = SSOF_SEQ_RUN;
                end
            end
            SSOF_SEQ_RUN: begin
                if (!IN_POSITION_IN) begin
                    next_state = SSOF_SEQ_WAIT;
                end
            end
            SSOF_SEQ_WAIT: begin
                if (IN_POSITION_IN) begin
                    next_state = SSOF_SEQ_IDLE;
                end
            end
            default: next_state = SSOF_SEQ_IDLE;
        endcase
        if (!seq_en || seq_block) begin
            next_state = SSOF_SEQ_IDLE;
        end
    end

    // R5 cancel and pause have no input here, so no effect
    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            state <= SSOF_SEQ_IDLE;
            next_entry <= 7'h01;
            cycle_end_mark <= 1'b0;
        end else begin
            state <= next_state;
            // R7 skip continued entries
            if (start_any && next_state == SSOF_SEQ_RUN) begin
                next_entry <= start_entry;
            end else if (state == SSOF_SEQ_WAIT && IN_POSITION_IN) begin
                next_entry <= (last_entry && !CONTINUATION_MARK_IN) ?
                    7'h01 : next_entry + 7'h01;
            end else if (state == SSOF_SEQ_IDLE && CONTINUATION_MARK_IN
                         && seq_en) begin
                next_entry <= next_entry + 7'h01;
            end
            // R4 suppressed when blocked; a hit beats a new start
            if (!seq_en || seq_block) begin
                cycle_end_mark <= 1'b0;
            end else if (cycle_end_mark_hit) begin
                cycle_end_mark <= 1'b1;
            end else if (start_any) begin
                cycle_end_mark <= 1'b0;
            end
        end
    end

    // R8 homing done latch
    wire signed [PW:0] hdiff = $signed({FB_POS_IN[PW-1], FB_POS_IN}) -
        $signed({HOME_POSITION_VALUE_IN[PW-1], HOME_POSITION_VALUE_IN});
    wire [PW:0] habs = hdiff[PW] ? -hdiff : hdiff;
    // R9 range 0 or max drops only while homing is active
    wire home_any = HOME_DETECT_RANGE_IN == '0 ||
        HOME_DETECT_RANGE_IN == '1;
    wire home_in = home_any || habs <= {1'b0, HOME_DETECT_RANGE_IN};
    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            home_done <= 1'b0;
        end else if (HOMING_DONE_IN) begin
            home_done <= 1'b1;
        end else if (HOMING_ACTIVE_IN || !home_in) begin
            home_done <= 1'b0;
        end
    end

    // R10 deviation window
    wire signed [PW:0] dev = $signed({CMD_POS_IN[PW-1], CMD_POS_IN}) -
        $signed({FB_POS_IN[PW-1], FB_POS_IN});
    wire [PW:0] dev_abs = dev[PW] ? -dev : dev;
    wire zdev = dev_abs <= {1'b0, ZERO_DEVIATION_WIDTH_IN};
    // R11 speed magnitude
    wire [SW-1:0] spd_abs = SPEED_IN[SW-1] ? SW'(-SPEED_IN) : SPEED_IN;
    wire zspd = spd_abs <= ZERO_SPEED_RANGE_IN;
    // R12 command speed source
    wire [2:0] fsel = FEED_SPEED_SEL_IN == 3'h0 ? 3'h0 :
        FEED_SPEED_SEL_IN - 3'h1;
    wire [SW-1:0] feed_spd = MANUAL_FEED_SPEEDS_IN[fsel*SW +: SW];
    wire [SW-1:0] raw_cmd = HOST_SPEED_SEL_IN ? HOST_SPEED_IN : feed_spd;
    // R15 clamp to maximum
    wire over_max = raw_cmd > MAX_ROTATION_SPEED_IN;
    wire [SW-1:0] cmd_spd = over_max ? MAX_ROTATION_SPEED_IN : raw_cmd;
    wire [SW:0] sdiff = spd_abs >= cmd_spd ?
        {1'b0, spd_abs} - {1'b0, cmd_spd} : {1'b0, cmd_spd} - {1'b0, spd_abs};
    // R13 mode gating
    wire mode_ok = CTRL_MODE_IN == SSOF_MODE_SPD || HOMING_ACTIVE_IN ||
        (CTRL_MODE_IN == SSOF_MODE_POS && INTERRUPT_POS_IN);
    // R14 manual blocking
    wire man_block = MANUAL_OP_IN && ((!FORWARD_JOG_COMMAND_IN &&
        !REVERSE_JOG_COMMAND_IN) || over_max || DECEL_SLOW_IN);
    wire spdm = mode_ok && !man_block && CTRL_MODE_IN != SSOF_MODE_TRQ &&
        sdiff <= {1'b0, SPEED_MATCH_RANGE_IN};
    // R16 at torque limit
    wire tlim = TORQUE_IN >= TORQUE_LIMIT_IN;
    // R17 level compare only, no reset path
    wire olw = LOAD_FACTOR_IN >= OVERLOAD_WARN_LEVEL_IN;
    // R18 ready conditions
    wire rdy = FORCED_STOP_INPUT_IN && !FREE_RUN_INPUT_IN && !ALARM_IN &&
        CPU_OK_IN && MAIN_POWER_IN;
    // R19 edit permission table
    wire edit = INTERNAL_DATA &&
        EDIT_PROTECT_SETTING_IN == `SSOF_PROTECT_OFF &&
        (!EDIT_PERMIT_ASSIGNED_IN || EDIT_PERMIT_IN);

    // R21 variant gating on cycle end
    // R23 flags registered every cycle
    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            flag <= '0;
            SPEED_CMD_OUT <= '0;
            EDIT_ALLOWED_OUT <= 1'b0;
        end else begin
            flag <= {edit, rdy, olw, tlim, spdm, zspd, zdev, home_done,
                     cycle_end_mark && INTERNAL_DATA};
            SPEED_CMD_OUT <= cmd_spd;
            EDIT_ALLOWED_OUT <= edit;
        end
    end
    assign fl.flag = flag;
    // host marks follow this value; a lagging copy would skip twice
    assign NEXT_ENTRY_OUT = next_entry;

    // R22 unmatched codes give zero
    ssof_term_map #(.NT(NT), .NF(`SSOF_NUM_FLAGS)) u_map (
        .clk(MCLK_IN),
        .rst_n(RSTN_IN),
        .fl(fl),
        .code(TERM_FUNC_CODE_IN),
        .term(TERM_OUT)
    );

    property p_cycle_end_mark_inpos;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        $rose(cycle_end_mark) |-> $past(IN_POSITION_IN);
    endproperty
    a_cycle_end_mark_inpos: assert property (p_cycle_end_mark_inpos) // R2
        else $error("cycle end rose without in-position");
    property p_cycle_end_mark_block;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (seq_block || !seq_en) |=> !cycle_end_mark;
    endproperty
    a_cycle_end_mark_block: assert property (p_cycle_end_mark_block) // R4
        else $error("cycle end while blocked");
    property p_zdev;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        zdev |=> flag[2];
    endproperty
    a_zdev: assert property (p_zdev) // R10
        else $error("zero deviation flag missed");
    property p_zspd;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        !zspd |=> !flag[3];
    endproperty
    a_zspd: assert property (p_zspd) // R11
        else $error("zero speed flag wrong");
    property p_trq;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        CTRL_MODE_IN == SSOF_MODE_TRQ && !HOMING_ACTIVE_IN |=> !flag[4];
    endproperty
    a_trq: assert property (p_trq) // R13
        else $error("speed match under torque control");
    property p_clamp;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        1'b1 |=> SPEED_CMD_OUT <= $past(MAX_ROTATION_SPEED_IN);
    endproperty
    a_clamp: assert property (p_clamp) // R15
        else $error("command speed above maximum");
    property p_olw;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        LOAD_FACTOR_IN < OVERLOAD_WARN_LEVEL_IN |=> !flag[6];
    endproperty
    a_olw: assert property (p_olw) // R17
        else $error("overload warning stuck");
    property p_rdy;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        (ALARM_IN || !FORCED_STOP_INPUT_IN) |=> !flag[7];
    endproperty
    a_rdy: assert property (p_rdy) // R18
        else $error("ready with alarm or stop");
    property p_edit;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        EDIT_PROTECT_SETTING_IN |=> !EDIT_ALLOWED_OUT;
    endproperty
    a_edit: assert property (p_edit) // R19
        else $error("edit allowed under protect");
    // R2 closing entry sets cycle end
    sequence s_close_entry;
        state == SSOF_SEQ_WAIT && IN_POSITION_IN && last_entry;
    endsequence
    sequence s_seq_free;
        seq_en && !seq_block;
    endsequence
    property p_cycle_end_mark_set;
        @(posedge MCLK_IN) disable iff (!RSTN_IN)
        s_close_entry and s_seq_free |=> cycle_end_mark;
    endproperty
    a_cycle_end_mark_set: assert property (p_cycle_end_mark_set) // R2
        else $error("cycle end missed at closing entry");
endmodule

// ==== design/ssof_term_map.sv ====
// maps flag vector onto output terminals by function code
// assumes codes are contiguous from the first flag code
`timescale 1ns/100ps
`include "ssof_regs.svh"
module ssof_term_map #(
    parameter int NT = 5,
    parameter int NF = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    ssof_flag_if.dst fl,
    input wire logic [NT*8-1:0] code,
    output logic [NT-1:0] term
);
    import ssof_pkg::*;
    initial begin
        if (NT < 1 || NF != `SSOF_NUM_FLAGS) begin
            $error("ssof_term_map: bad parameters");
        end
    end
    // one register process for the whole vector, one driver per bit
    wire [NT-1:0] sel_v;
    genvar i;
    generate
        for (i = 0; i < NT; i++) begin : g_term
            wire [7:0] c = code[i*8 +: 8];
            wire [7:0] idx = c - `SSOF_FIRST_CODE;
            wire in_rng = (c >= `SSOF_FIRST_CODE) &&
                (idx < 8'(NF));
            // R20 code selects flag
            assign sel_v[i] = in_rng ? fl.flag[idx[3:0]] : 1'b0;
        end
    endgenerate
    // R23 registered terminal
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            term <= '0;
        end else begin
            term <= sel_v;
        end
    end
endmodule

// ==== test/ssof_host_model.sv ====
// host controller model for the positioning sequence inputs
// assumes the bench calls move() and the device samples on rising edges
`timescale 1ns/100ps
module ssof_host_model #(
    parameter logic [6:0] CYCLE_END_MARK_ENTRY = 7'h07,
    parameter logic [6:0] CONT_ENTRY = 7'h06
) (
    // clock
    input wire logic clk_in,
    // device side
    input wire logic [6:0] next_entry_in,
    output logic start_pos_out,
    output logic [6:0] entry_num_out,
    output logic cycle_end_mark_out,
    output logic continuation_mark_out,
    output logic in_position_out
);
    // marks belong to the entry the device holds as next
    assign cycle_end_mark_out = next_entry_in == CYCLE_END_MARK_ENTRY;
    assign continuation_mark_out = next_entry_in == CONT_ENTRY;
    initial begin
        start_pos_out = 1'b0;
        entry_num_out = 7'h00;
        in_position_out = 1'b1;
    end
    task automatic move(input logic [6:0] entry, input int dly);
        @(negedge clk_in);
        start_pos_out = 1'b1;
        entry_num_out = entry;
        in_position_out = 1'b0;
        @(negedge clk_in);
        start_pos_out = 1'b0;
        // all entry lines low so later pulses only step
        entry_num_out = 7'h00;
        repeat (dly) @(negedge clk_in);
        in_position_out = 1'b1;
    endtask
endmodule

// ==== test/test_servo_status_output_flags.sv ====
// self-checking bench for the servo status flag block
// assumes terminal 2 carries the flag under test, others unassigned
`timescale 1ns/100ps
`include "ssof_regs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_servo_status_output_flags;
    import ssof_pkg::*;
    logic MCLK_IN, RSTN_IN, SEQUENTIAL_START_SELECT_IN, INTERNAL_DATA_SELECT_IN;
    logic [23:0] ZERO_DEVIATION_WIDTH_IN, HOME_POSITION_VALUE_IN;
    logic [23:0] HOME_DETECT_RANGE_IN;
    logic [15:0] ZERO_SPEED_RANGE_IN, SPEED_MATCH_RANGE_IN, MAX_ROTATION_SPEED_IN;
    logic [15:0] HOST_SPEED_IN, TORQUE_IN, TORQUE_LIMIT_IN, SPEED_CMD_OUT;
    logic [111:0] MANUAL_FEED_SPEEDS_IN;
    logic [7:0] OVERLOAD_WARN_LEVEL_IN, LOAD_FACTOR_IN;
    logic [39:0] TERM_FUNC_CODE_IN;
    wire START_POS_IN, CYCLE_END_MARK_IN, CONTINUATION_MARK_IN, IN_POSITION_IN;
    wire [6:0] ENTRY_NUM_IN;
    wire SERVO_ON_IN, PULSE_RATIO_IN, HOMING_ACTIVE_IN, OVER_TRAVEL_INPUT_IN;
    wire SOFT_OT_IN, FORCED_STOP_INPUT_IN, FREE_RUN_INPUT_IN, ALARM_IN;
    wire CPU_OK_IN, MAIN_POWER_IN, EDIT_PROTECT_SETTING_IN;
    wire EDIT_PERMIT_ASSIGNED_IN, EDIT_PERMIT_IN;
    logic HOMING_DONE_IN, INTERRUPT_POS_IN, MANUAL_OP_IN, HOST_SPEED_SEL_IN;
    logic FORWARD_JOG_COMMAND_IN, REVERSE_JOG_COMMAND_IN, DECEL_SLOW_IN;
    ssof_mode_e CTRL_MODE_IN;
    logic [2:0] FEED_SPEED_SEL_IN, ed;
    logic signed [23:0] CMD_POS_IN, FB_POS_IN;
    logic signed [15:0] SPEED_IN;
    logic [4:0] TERM_OUT, blk, rdy;
    logic EDIT_ALLOWED_OUT;
    logic [6:0] NEXT_ENTRY_OUT;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    // grouped levels so loops can sweep them
    assign SERVO_ON_IN = ~blk[0];
    assign {PULSE_RATIO_IN, HOMING_ACTIVE_IN, OVER_TRAVEL_INPUT_IN} = blk[3:1];
    assign SOFT_OT_IN = blk[4];
    assign {FORCED_STOP_INPUT_IN, FREE_RUN_INPUT_IN, ALARM_IN} = rdy[4:2];
    assign {CPU_OK_IN, MAIN_POWER_IN} = rdy[1:0];
    assign {EDIT_PROTECT_SETTING_IN, EDIT_PERMIT_ASSIGNED_IN} = ed[2:1];
    assign EDIT_PERMIT_IN = ed[0];

    ssof_status #(.NT(5), .PW(24), .SW(16), .INTERNAL_DATA(1'b1))
        i_ssof_status (.*);
    ssof_host_model i_ssof_host_model (.clk_in(MCLK_IN),
        .next_entry_in(NEXT_ENTRY_OUT), .start_pos_out(START_POS_IN),
        .entry_num_out(ENTRY_NUM_IN), .cycle_end_mark_out(CYCLE_END_MARK_IN),
        .continuation_mark_out(CONTINUATION_MARK_IN),
        .in_position_out(IN_POSITION_IN));

    initial begin
        MCLK_IN = 1'b0;
        forever #10 MCLK_IN = ~MCLK_IN;
    end

    task automatic summarize;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // flag on terminal 2 only; two cycles of latency plus margin
    task automatic chk(input logic [7:0] code, input logic exp);
        TERM_FUNC_CODE_IN = {16'h0000, code, 16'h0000};
        repeat (3) @(negedge MCLK_IN);
        `CHK(TERM_OUT, {2'b00, exp, 2'b00})
    endtask

    task automatic seq_cycle_end_mark(input logic [6:0] first, input logic exp);
        i_ssof_host_model.move(first, 4);
        i_ssof_host_model.move(7'h00, 6);
        chk(`SSOF_CODE_CYCLE_END_MARK, exp);
        `CHK(NEXT_ENTRY_OUT, 7'h01)
    endtask

    task automatic home_pulse;
        HOMING_DONE_IN = 1'b1;
        @(negedge MCLK_IN);
        HOMING_DONE_IN = 1'b0;
    endtask

    always @(posedge MCLK_IN) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end

    initial begin
        RSTN_IN = 1'b0;
        {SEQUENTIAL_START_SELECT_IN, INTERNAL_DATA_SELECT_IN} = 2'b00;
        {HOMING_DONE_IN, INTERRUPT_POS_IN, MANUAL_OP_IN} = 3'b000;
        {FORWARD_JOG_COMMAND_IN, REVERSE_JOG_COMMAND_IN} = 2'b00;
        {HOST_SPEED_SEL_IN, DECEL_SLOW_IN} = 2'b10;
        {blk, ed, rdy} = {5'h00, 3'h0, 5'h13};
        ZERO_DEVIATION_WIDTH_IN = 24'h000004;
        HOME_POSITION_VALUE_IN = 24'h0003e8;
        HOME_DETECT_RANGE_IN = 24'h000032;
        {ZERO_SPEED_RANGE_IN, SPEED_MATCH_RANGE_IN} = {16'h000a, 16'h000a};
        {MAX_ROTATION_SPEED_IN, HOST_SPEED_IN} = {16'h0bb8, 16'h03e8};
        {TORQUE_IN, TORQUE_LIMIT_IN} = {16'h012c, 16'h012c};
        MANUAL_FEED_SPEEDS_IN = {64'h0, 16'h07d0, 32'h0};
        {OVERLOAD_WARN_LEVEL_IN, LOAD_FACTOR_IN} = 16'h5050;
        TERM_FUNC_CODE_IN = 40'h0;
        CTRL_MODE_IN = SSOF_MODE_SPD;
        FEED_SPEED_SEL_IN = 3'h3;
        {CMD_POS_IN, FB_POS_IN} = {24'sd100, 24'sd96};
        SPEED_IN = 16'sd10;
        repeat (5) @(negedge MCLK_IN);
        RSTN_IN = 1'b1;
        chk(`SSOF_CODE_ZSPD, 1'b1);
        SPEED_IN = -16'sd10;
        chk(`SSOF_CODE_ZSPD, 1'b1);
        SPEED_IN = 16'sd11;
        chk(`SSOF_CODE_ZSPD, 1'b0);
        chk(`SSOF_CODE_ZDEV, 1'b1);
        FB_POS_IN = 24'sd95;
        chk(`SSOF_CODE_ZDEV, 1'b0);
        chk(`SSOF_CODE_TLIM, 1'b1);
        TORQUE_IN = 16'h012b;
        chk(`SSOF_CODE_TLIM, 1'b0);
        chk(`SSOF_CODE_OLW, 1'b1);
        LOAD_FACTOR_IN = 8'h4f;
        chk(`SSOF_CODE_OLW, 1'b0);
        for (int i = 0; i < 6; i++) begin
            rdy = (i == 0) ? 5'h13 : 5'h13 ^ (5'h01 << (i - 1));
            chk(`SSOF_CODE_RDY, i == 0);
        end
        for (int i = 0; i < 6; i++) begin
            ed = {i >= 3, (i % 3) != 0, (i % 3) == 2};
            chk(`SSOF_CODE_EDIT, i == 0 || i == 2);
            `CHK(EDIT_ALLOWED_OUT, i == 0 || i == 2)
        end
        SPEED_IN = 16'sd1010;
        chk(`SSOF_CODE_SPDM, 1'b1);
        `CHK(SPEED_CMD_OUT, 16'h03e8)
        SPEED_IN = 16'sd1011;
        chk(`SSOF_CODE_SPDM, 1'b0);
        SPEED_IN = 16'sd995;
        CTRL_MODE_IN = SSOF_MODE_TRQ;
        chk(`SSOF_CODE_SPDM, 1'b0);
        CTRL_MODE_IN = SSOF_MODE_POS;
        INTERRUPT_POS_IN = 1'b1;
        chk(`SSOF_CODE_SPDM, 1'b1);
        CTRL_MODE_IN = SSOF_MODE_SPD;
        MANUAL_OP_IN = 1'b1;
        chk(`SSOF_CODE_SPDM, 1'b0);
        FORWARD_JOG_COMMAND_IN = 1'b1;
        chk(`SSOF_CODE_SPDM, 1'b1);
        DECEL_SLOW_IN = 1'b1;
        chk(`SSOF_CODE_SPDM, 1'b0);
        {DECEL_SLOW_IN, HOST_SPEED_SEL_IN} = 2'b00;
        SPEED_IN = 16'sd2000;
        chk(`SSOF_CODE_SPDM, 1'b1);
        `CHK(SPEED_CMD_OUT, 16'h07d0)
        MAX_ROTATION_SPEED_IN = 16'h01f4;
        SPEED_IN = 16'sd500;
        chk(`SSOF_CODE_SPDM, 1'b0);
        `CHK(SPEED_CMD_OUT, 16'h01f4)
        FB_POS_IN = 24'sd1020;
        home_pulse();
        chk(`SSOF_CODE_HOME, 1'b1);
        FB_POS_IN = 24'sd1100;
        chk(`SSOF_CODE_HOME, 1'b0);
        for (int i = 0; i < 2; i++) begin
            HOME_DETECT_RANGE_IN = (i == 0) ? 24'h000000 : 24'hffffff;
            home_pulse();
            FB_POS_IN = 24'sd5000;
            chk(`SSOF_CODE_HOME, 1'b1);
        end
        seq_cycle_end_mark(7'h05, 1'b0);
        {SEQUENTIAL_START_SELECT_IN, INTERNAL_DATA_SELECT_IN} = 2'b11;
        seq_cycle_end_mark(7'h05, 1'b1);
        seq_cycle_end_mark(7'h62, 1'b1);
        for (int k = 0; k < 5; k++) begin
            seq_cycle_end_mark(7'h05, 1'b1);
            blk = 5'h01 << k;
            chk(`SSOF_CODE_CYCLE_END_MARK, 1'b0);
            blk = 5'h00;
        end
        summarize();
    end
endmodule
